// ### mac_cfg_pkg.sv
// Offsets, bit positions and reset values of the MAC configuration words
// How it works
// - Length/type bit 25 set skips the length/type check on receive.
// - Control length bit 24 set lets longer control frames through.
// - Timestamp bit 22 adds in-line timestamps beside the sideband copy.
// - Without timestamp support the in-line timestamp bit has no effect.
// - Bits 21 to 16 of the second receive word (0x404) always read as zero.
// - Bits 15:0 hold the pause address top, reset all ones, matched on receive.
// - Transmitter uses the same pause address as flow-control source.
// - First wire byte of the pause address sits in the lowest byte.
// - A frame is tagged only when its type field equals 0x8100.
// - Transmit word writes any time, applied only in an idle gap.
// - Transmit reset bit acts at once, not waiting for a gap.
// - Writing one to transmit bit 31 resets the transmitter, bit self-clears.
// - Transmitter reset returns its configuration to defaults.
// - Transmit bit 30 allows frames beyond standard length, else blocked.
// - Receive word writes apply between frames; its reset bit acts at once.
package mac_cfg_pkg;
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] RX_WORD0_OFS  = 12'h400;
    localparam logic [11:0] RX_WORD1_OFS  = 12'h404;
    localparam logic [11:0] TX_WORD_OFS   = 12'h408;
    localparam int          RST_BIT       = 31;
    localparam int          JUMBO_BIT     = 30;
    localparam int          FCS_BIT       = 29;
    localparam int          EN_BIT        = 28;
    localparam int          VLAN_BIT      = 27;
    localparam int          HD_BIT        = 26;
    localparam int          LT_BIT        = 25;
    localparam int          IFG_BIT       = 25;
    localparam int          CL_BIT        = 24;
    localparam int          TS_BIT        = 22;
    localparam logic [31:0] RX_WORD0_RST  = 32'hffffffff;
    localparam logic [31:0] RX_WORD1_RST  = 32'h1000ffff;
    localparam logic [31:0] RX_WORD1_MASK = 32'h7f40ffff;
    localparam logic [31:0] TX_WORD_RST   = 32'h10000000;
    localparam logic [31:0] TX_WORD_MASK  = 32'h7e000000;
    localparam logic [15:0] VLAN_TAG_PROTOCOL_IDENTIFIER     = 16'h8100;
    localparam logic [15:0] STD_MAX_LEN   = 16'h05ee;
    localparam logic [15:0] VLAN_EXTRA    = 16'h0004;
endpackage

// ### cfg_gap_apply.sv
// Shadow copy of a configuration word, loaded only in an idle gap, set to its reset value at once on flush
`timescale 1ns/1ps
`default_nettype none
module cfg_gap_apply #(
    parameter int          W       = 32,
    parameter logic [31:0] RST_VAL = 32'h0
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         srst,
    // Stored value and timing
    input  wire logic [W-1:0] cfgIn,
    input  wire logic         gap,
    input  wire logic         flush,
    // Value in force
    output logic      [W-1:0] cfgOut
);
    typedef struct packed {
        logic [W-1:0] cfg;
    } state_t;

    state_t q;
    state_t d;

    always_comb begin
        d = q;
        if (srst || flush) begin
            d.cfg = RST_VAL[W-1:0];
        end else if (gap) begin
            d.cfg = cfgIn;
        end
    end

    always_ff @(posedge mclk) begin
        q <= d;
    end

    assign cfgOut = q.cfg;

    AST_GAP_HOLD: assert property (@(posedge mclk) disable iff (srst)
        !srst && !gap && !flush |=> $stable(cfgOut))
        else $error("Configuration changed outside a gap");
    AST_FLUSH_NOW: assert property (@(posedge mclk) disable iff (srst)
        flush |=> cfgOut == RST_VAL[W-1:0])
        else $error("Reset did not restore defaults at once");
endmodule
`default_nettype wire

// ### field_match.sv
// Registered compare of a received field against a reference value
`timescale 1ns/1ps
`default_nettype none
module field_match #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         srst,
    // Compare request
    input  wire logic         en,
    input  wire logic         valid,
    input  wire logic [W-1:0] value,
    input  wire logic [W-1:0] refVal,
    // Result
    output logic              hit,
    output logic              hitValid
);
    typedef struct packed {
        logic hit;
        logic hitValid;
    } state_t;

    state_t q;
    state_t d;

    always_comb begin
        d          = q;
        d.hitValid = valid;
        d.hit      = valid && en && (value == refVal);
        if (srst) begin
            d = '0;
        end
    end

    always_ff @(posedge mclk) begin
        q <= d;
    end

    assign hit      = q.hit;
    assign hitValid = q.hitValid;
endmodule
`default_nettype wire

// ### mac_rx_tx_config_regs.sv
// Receive and transmit configuration registers of the MAC
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mac_rx_tx_config_regs
    import mac_cfg_pkg::*;
#(
    parameter bit PTP_PRESENT = 1'b1
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              srst,
    // Register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [31:0]       regWdata,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [31:0]       regRdata,
    // Receive path status and fields
    input  wire logic              rxGap,
    input  wire logic [47:0]       rxDestAddr,
    input  wire logic              rxDestValid,
    input  wire logic [15:0]       rxTypeField,
    input  wire logic              rxTypeValid,
    // Receive path controls
    output logic                   rxReset,
    output logic                   rxJumboOn,
    output logic                   rxFcsInband,
    output logic                   rxEnable,
    output logic                   rxVlanOn,
    output logic                   rxHalfDuplex,
    output logic                   rxLenTypeCheckOn,
    output logic                   rxCtrlLenCheckOn,
    output logic                   rxInbandTs,
    output logic                   rxPauseHit,
    output logic                   rxPauseHitValid,
    output logic                   rxVlanTagged,
    output logic                   rxVlanValid,
    // Transmit path status and fields
    input  wire logic              txGap,
    input  wire logic [15:0]       txFrameLen,
    // Transmit path controls
    output logic                   txReset,
    output logic                   txJumboOn,
    output logic                   txFcsInband,
    output logic                   txEnable,
    output logic                   txVlanOn,
    output logic                   txHalfDuplex,
    output logic                   txIfgAdjust,
    output logic                   txOversizeBlock,
    output logic      [47:0]       txPauseSrcAddr
);
    typedef struct packed {
        logic [31:0] rxWord0;
        logic [31:0] rxWord1;
        logic [31:0] txWord;
        logic [31:0] rdata;
        logic        rxRst;
        logic        txRst;
    } state_t;

    state_t      q;
    state_t      d;
    logic        rxRstWr;
    logic        txRstWr;
    logic [31:0] rxApplied0;
    logic [31:0] rxApplied1;
    logic [31:0] txApplied;
    logic [47:0] flow_ctrl_mac_address;
    logic [15:0] txMaxLen;

    // Reset bits act in the write cycle itself
    assign rxRstWr = regWrite && regAddr == RX_WORD1_OFS
                     && regWdata[RST_BIT];
    assign txRstWr = regWrite && regAddr == TX_WORD_OFS
                     && regWdata[RST_BIT];

    always_comb begin
        d       = q;
        d.rxRst = 1'b0;
        d.txRst = 1'b0;
        d.rdata = 32'h00000000;
        // Receive words
        if (rxRstWr) begin
            d.rxWord0 = RX_WORD0_RST;
            d.rxWord1 = RX_WORD1_RST;
            d.rxRst   = 1'b1;
        end else if (regWrite && regAddr == RX_WORD0_OFS) begin
            d.rxWord0 = regWdata;
        end else if (regWrite && regAddr == RX_WORD1_OFS) begin
            d.rxWord1 = regWdata & RX_WORD1_MASK;
        end
        // Transmit word
        if (txRstWr) begin
            d.txWord = TX_WORD_RST;
            d.txRst  = 1'b1;
        end else if (regWrite && regAddr == TX_WORD_OFS) begin
            d.txWord = regWdata & TX_WORD_MASK;
        end
        // Read data stands one cycle after the strobe
        if (regRead) begin
            case (regAddr)
                RX_WORD0_OFS: d.rdata = q.rxWord0;
                RX_WORD1_OFS: d.rdata = q.rxWord1 & RX_WORD1_MASK;
                TX_WORD_OFS:  d.rdata = q.txWord & TX_WORD_MASK;
                default:      d.rdata = 32'h00000000;
            endcase
        end
        if (srst) begin
            d.rxWord0 = RX_WORD0_RST;
            d.rxWord1 = RX_WORD1_RST;
            d.txWord  = TX_WORD_RST;
            d.rdata   = 32'h00000000;
            d.rxRst   = 1'b0;
            d.txRst   = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        q <= d;
    end

    assign regRdata = q.rdata;
    assign rxReset  = q.rxRst;
    assign txReset  = q.txRst;

    // Values in force, refreshed in gaps
    cfg_gap_apply #(
        .W       (32),
        .RST_VAL (RX_WORD0_RST)
    ) rxApply0 (
        .mclk   (mclk),
        .srst   (srst),
        .cfgIn  (q.rxWord0),
        .gap    (rxGap),
        .flush  (rxRstWr),
        .cfgOut (rxApplied0)
    );

    cfg_gap_apply #(
        .W       (32),
        .RST_VAL (RX_WORD1_RST)
    ) rxApply1 (
        .mclk   (mclk),
        .srst   (srst),
        .cfgIn  (q.rxWord1),
        .gap    (rxGap),
        .flush  (rxRstWr),
        .cfgOut (rxApplied1)
    );

    cfg_gap_apply #(
        .W       (32),
        .RST_VAL (TX_WORD_RST)
    ) txApply (
        .mclk   (mclk),
        .srst   (srst),
        .cfgIn  (q.txWord),
        .gap    (txGap),
        .flush  (txRstWr),
        .cfgOut (txApplied)
    );

    // Receive controls
    assign rxJumboOn        = rxApplied1[JUMBO_BIT];
    assign rxFcsInband      = rxApplied1[FCS_BIT];
    assign rxEnable         = rxApplied1[EN_BIT];
    assign rxVlanOn         = rxApplied1[VLAN_BIT];
    assign rxHalfDuplex     = rxApplied1[HD_BIT];
    assign rxLenTypeCheckOn = !rxApplied1[LT_BIT];
    assign rxCtrlLenCheckOn = !rxApplied1[CL_BIT];
    assign rxInbandTs       = PTP_PRESENT
                              && rxApplied1[TS_BIT];

    // First wire byte lowest
    assign flow_ctrl_mac_address = {rxApplied1[15:0], rxApplied0};

    field_match #(
        .W (48)
    ) pauseMatch (
        .mclk     (mclk),
        .srst     (srst),
        .en       (1'b1),
        .valid    (rxDestValid),
        .value    (rxDestAddr),
        .refVal   (flow_ctrl_mac_address),
        .hit      (rxPauseHit),
        .hitValid (rxPauseHitValid)
    );

    field_match #(
        .W (16)
    ) vlanMatch (
        .mclk     (mclk),
        .srst     (srst),
        .en       (rxVlanOn),
        .valid    (rxTypeValid),
        .value    (rxTypeField),
        .refVal   (VLAN_TAG_PROTOCOL_IDENTIFIER),
        .hit      (rxVlanTagged),
        .hitValid (rxVlanValid)
    );

    // Transmit controls
    assign txJumboOn      = txApplied[JUMBO_BIT];
    assign txFcsInband    = txApplied[FCS_BIT];
    assign txEnable       = txApplied[EN_BIT];
    assign txVlanOn       = txApplied[VLAN_BIT];
    assign txHalfDuplex   = txApplied[HD_BIT];
    assign txIfgAdjust    = txApplied[IFG_BIT];
    assign txPauseSrcAddr = flow_ctrl_mac_address;

    assign txMaxLen = txVlanOn ? 16'(STD_MAX_LEN + VLAN_EXTRA) : STD_MAX_LEN;
    assign txOversizeBlock = !txJumboOn
                             && txFrameLen > txMaxLen;

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    sequence rxWriteInGap;
        rxGap && regWrite && regAddr == RX_WORD1_OFS && !regWdata[RST_BIT]
        ##1 rxGap && !rxRstWr;
    endsequence

    sequence txRstWrite;
        regWrite && regAddr == TX_WORD_OFS && regWdata[RST_BIT];
    endsequence

    sequence rxLtWriteInGap;
        rxGap && regWrite && regAddr == RX_WORD1_OFS
        && regWdata[LT_BIT] && !regWdata[RST_BIT] ##1 rxGap && !rxRstWr;
    endsequence

    sequence txJumboWriteNoGap;
        !txGap && !txJumboOn && regWrite && regAddr == TX_WORD_OFS
        && regWdata[JUMBO_BIT] && !regWdata[RST_BIT] ##1 !txGap;
    endsequence

    AST_TX_RST_PULSE: assert property (
        txRstWrite |=> txReset ##1 !txReset)
        else $error("Transmit reset pulse wrong");
    AST_TX_RST_DEFAULT: assert property (
        txRstWrite |=> !txJumboOn && txEnable && !txIfgAdjust)
        else $error("Transmit defaults not restored");
    AST_TX_RST_READ: assert property (
        regRead && regAddr == TX_WORD_OFS |=> !regRdata[RST_BIT])
        else $error("Transmit reset bit reads as one");
    AST_TX_GAP_WAIT: assert property (
        txJumboWriteNoGap |=> !txJumboOn)
        else $error("Transmit change applied outside gap");
    AST_RX_LT_APPLY: assert property (
        rxLtWriteInGap |=> !rxLenTypeCheckOn)
        else $error("Length check disable not applied");
    AST_RX_RESERVED: assert property (
        regRead && regAddr == RX_WORD1_OFS
        |=> regRdata[21:16] == 6'h00 && !regRdata[23] && !regRdata[RST_BIT])
        else $error("Reserved receive bits not zero");
    AST_RX_RST_NOW: assert property (
        regWrite && regAddr == RX_WORD1_OFS && regWdata[RST_BIT]
        |=> rxReset && txPauseSrcAddr[47:32] == 16'hffff)
        else $error("Receive reset not immediate");
    AST_TS_GATE: assert property (
        rxWriteInGap
        |=> rxInbandTs == (PTP_PRESENT && $past(regWdata[TS_BIT], 2)))
        else $error("In-line timestamp bit not applied as built");
    AST_PAUSE_HIT: assert property (
        rxDestValid && rxDestAddr == flow_ctrl_mac_address
        |=> rxPauseHit && rxPauseHitValid)
        else $error("Pause address match missed");
    AST_VLAN_TAG_PROTOCOL_IDENTIFIER: assert property (
        rxTypeValid && rxTypeField != VLAN_TAG_PROTOCOL_IDENTIFIER |=> !rxVlanTagged)
        else $error("Wrong identifier taken as tag");
    AST_TX_OVERSIZE: assert property (
        !txJumboOn && txFrameLen > STD_MAX_LEN + VLAN_EXTRA
        |-> txOversizeBlock)
        else $error("Oversize frame not blocked");

    sequence rxWriteNoGap;
        !rxGap && regWrite && regAddr == RX_WORD1_OFS && !regWdata[RST_BIT]
        ##1 !rxGap && !rxRstWr;
    endsequence

    sequence txWriteInGap;
        txGap && regWrite && regAddr == TX_WORD_OFS && !regWdata[RST_BIT]
        ##1 txGap && !txRstWr;
    endsequence

    AST_TX_GAP_APPLY: assert property (
        txWriteInGap |=> txJumboOn == $past(regWdata[JUMBO_BIT], 2))
        else $error("Transmit change not applied in gap");
    AST_RX_CL_APPLY: assert property (
        rxWriteInGap |=> rxCtrlLenCheckOn == !$past(regWdata[CL_BIT], 2))
        else $error("Control length disable not applied");
    AST_RX_GAP_WAIT: assert property (
        rxWriteNoGap |=> $stable(rxLenTypeCheckOn) && $stable(rxInbandTs))
        else $error("Receive change applied outside gap");
    AST_RX_RST_IDLE: assert property (
        !rxRstWr |=> !rxReset)
        else $error("Receive reset without reset write");
    AST_TX_RST_IDLE: assert property (
        !txRstWr |=> !txReset)
        else $error("Transmit reset without reset write");
    AST_VLAN_HIT: assert property (
        rxTypeValid && rxVlanOn && rxTypeField == VLAN_TAG_PROTOCOL_IDENTIFIER
        |=> rxVlanTagged && rxVlanValid)
        else $error("Tag identifier not recognised");
    AST_TX_IN_LIMIT: assert property (
        txFrameLen <= STD_MAX_LEN |-> !txOversizeBlock)
        else $error("Standard length frame blocked");
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the MAC configuration registers
`timescale 1ns/1ps
`default_nettype none
module testbench
    import mac_cfg_pkg::*;
;
    logic              mclk, srst, regWrite, regRead, rdPend;
    logic [ADDR_W-1:0] regAddr;
    logic [31:0]       regWdata, regRdata, seed, r;
    logic              rxGap, rxDestValid, rxTypeValid, txGap;
    logic [47:0]       rxDestAddr, pa;
    logic [15:0]       rxTypeField, txFrameLen;
    logic rxReset, rxJumboOn, rxFcsInband, rxEnable, rxVlanOn, rxHalfDuplex;
    logic rxLenTypeCheckOn, rxCtrlLenCheckOn, rxInbandTs, rxPauseHit;
    logic rxPauseHitValid, rxVlanTagged, rxVlanValid;
    logic txReset, txJumboOn, txFcsInband, txEnable, txVlanOn, txHalfDuplex;
    logic txIfgAdjust, txOversizeBlock;
    logic [47:0]       txPauseSrcAddr;
    logic [31:0]       rdQ[$];
    logic              hitQ[$], vlanQ[$];
    int                n_mismatch, check_count, cycles;

    mac_rx_tx_config_regs mac_rx_tx_config_regs_inst (
        .mclk(mclk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .rxGap(rxGap), .rxDestAddr(rxDestAddr), .rxDestValid(rxDestValid),
        .rxTypeField(rxTypeField), .rxTypeValid(rxTypeValid),
        .rxReset(rxReset), .rxJumboOn(rxJumboOn), .rxFcsInband(rxFcsInband),
        .rxEnable(rxEnable), .rxVlanOn(rxVlanOn),
        .rxHalfDuplex(rxHalfDuplex), .rxLenTypeCheckOn(rxLenTypeCheckOn),
        .rxCtrlLenCheckOn(rxCtrlLenCheckOn), .rxInbandTs(rxInbandTs),
        .rxPauseHit(rxPauseHit), .rxPauseHitValid(rxPauseHitValid),
        .rxVlanTagged(rxVlanTagged), .rxVlanValid(rxVlanValid),
        .txGap(txGap), .txFrameLen(txFrameLen), .txReset(txReset),
        .txJumboOn(txJumboOn), .txFcsInband(txFcsInband),
        .txEnable(txEnable), .txVlanOn(txVlanOn),
        .txHalfDuplex(txHalfDuplex), .txIfgAdjust(txIfgAdjust),
        .txOversizeBlock(txOversizeBlock), .txPauseSrcAddr(txPauseSrcAddr)
    );

    always #2 mclk = ~mclk;

    // Pseudo-random source
    function automatic logic [31:0] rnd();
        for (int i = 0; i < 32; i++) begin
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        end
        return seed;
    endfunction

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (rdQ.size() + hitQ.size() + vlanQ.size() != 0) begin
            n_mismatch++;
            $display("[ERR] %0t expected results never appeared", $time);
        end
        $display("Counts: %0d checks, %0d mismatches", check_count,
                 n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Register bus and stimulus tasks
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rdQ.push_back(e);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
    endtask

    task automatic dest(input logic [47:0] a, input logic e);
        hitQ.push_back(e);
        @(posedge mclk);
        rxDestAddr  <= a;
        rxDestValid <= 1'b1;
        @(posedge mclk);
        rxDestValid <= 1'b0;
        rxDestAddr  <= ~a;
    endtask

    task automatic typ(input logic [15:0] t, input logic e);
        vlanQ.push_back(e);
        @(posedge mclk);
        rxTypeField <= t;
        rxTypeValid <= 1'b1;
        @(posedge mclk);
        rxTypeValid <= 1'b0;
        rxTypeField <= ~t;
    endtask

    task automatic gap(input logic isTx);
        @(posedge mclk);
        if (isTx) txGap <= 1'b1; else rxGap <= 1'b1;
        repeat (2) @(posedge mclk);
        txGap <= 1'b0;
        rxGap <= 1'b0;
        @(negedge mclk);
    endtask

    task automatic lenChk(input logic [15:0] len, input logic e);
        @(posedge mclk);
        txFrameLen <= len;
        @(negedge mclk);
        chk(txOversizeBlock, e);
    endtask

    // Result watcher
    always @(posedge mclk) begin
        rdPend <= regRead;
        if (rdPend && rdQ.size() > 0) chk(regRdata, rdQ.pop_front());
        if (rxPauseHitValid && hitQ.size() > 0)
            chk(rxPauseHit, hitQ.pop_front());
        if (rxVlanValid && vlanQ.size() > 0)
            chk(rxVlanTagged, vlanQ.pop_front());
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial begin
        mclk = 0; srst = 1; regWrite = 0; regRead = 0; rdPend = 0;
        regAddr = '0; regWdata = '0; seed = 32'h53; rxGap = 0; txGap = 0;
        rxDestAddr = '0; rxDestValid = 0; rxTypeField = '0; rxTypeValid = 0;
        txFrameLen = 16'h0040; n_mismatch = 0; check_count = 0; cycles = 0;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        rd(12'h404, 32'h1000ffff);
        rd(12'h408, 32'h10000000);
        rd(12'h400, 32'hffffffff);
        rd(12'h40c, 32'h00000000);
        @(negedge mclk);
        chk(rxLenTypeCheckOn, 1'b1);
        chk(rxCtrlLenCheckOn, 1'b1);
        chk(txPauseSrcAddr, 48'hffffffffffff);
        dest(48'hffffffffffff, 1'b1);
        r = rnd();
        wr(12'h400, r);
        wr(12'h404, {16'h7fff, r[15:0]});
        rd(12'h404, {16'h7f40, r[15:0]});
        @(negedge mclk);
        chk(rxLenTypeCheckOn, 1'b1);
        chk(rxInbandTs, 1'b0);
        gap(1'b0);
        chk(rxLenTypeCheckOn, 1'b0);
        chk(rxCtrlLenCheckOn, 1'b0);
        chk(rxInbandTs, 1'b1);
        chk(rxJumboOn, 1'b1);
        chk(rxFcsInband, 1'b1);
        chk(rxEnable, 1'b1);
        chk(rxVlanOn, 1'b1);
        chk(rxHalfDuplex, 1'b1);
        pa = {r[15:0], r};
        dest(pa, 1'b1);
        dest(pa ^ 48'h000000000001, 1'b0);
        dest(pa ^ 48'h800000000000, 1'b0);
        typ(16'h8100, 1'b1);
        typ(16'h8101, 1'b0);
        typ(16'h88a8, 1'b0);
        wr(12'h408, 32'h58000000);
        rd(12'h408, 32'h58000000);
        txFrameLen <= 16'd1600;
        @(negedge mclk);
        chk(txJumboOn, 1'b0);
        chk(txOversizeBlock, 1'b1);
        gap(1'b1);
        chk(txJumboOn, 1'b1);
        chk(txOversizeBlock, 1'b0);
        chk(txPauseSrcAddr, pa);
        chk(txFcsInband, 1'b0);
        chk(txVlanOn, 1'b1);
        chk(txHalfDuplex, 1'b0);
        chk(txIfgAdjust, 1'b0);
        wr(12'h408, 32'h18000000);
        gap(1'b1);
        lenChk(16'd1522, 1'b0);
        lenChk(16'd1523, 1'b1);
        wr(12'h408, 32'h10000000);
        gap(1'b1);
        lenChk(16'd1518, 1'b0);
        lenChk(16'd1519, 1'b1);
        r = rnd();
        wr(12'h408, {1'b0, r[30:0]});
        rd(12'h408, r & TX_WORD_MASK);
        gap(1'b1);
        chk(txFcsInband, r[29]);
        chk(txEnable, r[28]);
        chk(txVlanOn, r[27]);
        chk(txHalfDuplex, r[26]);
        chk(txIfgAdjust, r[25]);
        wr(12'h408, 32'h40000000);
        gap(1'b1);
        wr(12'h408, 32'h80000000);
        @(negedge mclk);
        chk(txReset, 1'b1);
        chk(txJumboOn, 1'b0);
        chk(txEnable, 1'b1);
        @(negedge mclk);
        chk(txReset, 1'b0);
        chk(rxLenTypeCheckOn, 1'b0);
        rd(12'h408, 32'h10000000);
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        rd(12'h404, 32'h1000ffff);
        rxGap <= 1'b1;
        txGap <= 1'b1;
        wr(12'h400, 32'h12345678);
        wr(12'h404, 32'h03400000);
        wr(12'h408, 32'h50000000);
        @(posedge mclk);
        rxGap <= 1'b0;
        txGap <= 1'b0;
        @(negedge mclk);
        chk(rxLenTypeCheckOn, 1'b0);
        chk(rxCtrlLenCheckOn, 1'b0);
        chk(txJumboOn, 1'b1);
        chk(txPauseSrcAddr, 48'h000012345678);
        wr(12'h404, 32'h80000000);
        @(negedge mclk);
        chk(rxReset, 1'b1);
        chk(rxLenTypeCheckOn, 1'b1);
        chk(txPauseSrcAddr, 48'hffffffffffff);
        rd(12'h404, 32'h1000ffff);
        rd(12'h400, 32'hffffffff);
        repeat (4) @(posedge mclk);
        print_verdict();
    end
endmodule
`default_nettype wire
